// *** shared/uul_defines.vh ***
// Constants for the user-unit and limit-switch reaction block.
// Assumes a 50 MHz system clock and word-aligned APB register access.
`ifndef UUL_DEFINES_VH
`define UUL_DEFINES_VH
// Register indices; the byte address is four times the index
`define UUL_IDX_POS_UNIT   16'h60A8
`define UUL_IDX_SPD_UNIT   16'h60A9
`define UUL_IDX_FACT_BASE  16'h6100
`define UUL_IDX_REACT      16'h6108
`define UUL_IDX_STATUS     16'h6109
`define UUL_IDX_LAT_FWD    16'h610A
`define UUL_IDX_LAT_REV    16'h610B
// Storage slots inside the configuration store
`define UUL_SLOT_POS       4'h0
`define UUL_SLOT_SPD       4'h1
`define UUL_SLOT_LAST      4'h9
`define UUL_SLOT_NONE      4'hF
// Field layout of the unit words
`define UUL_EXP_MSB        31
`define UUL_EXP_LSB        24
`define UUL_UNIT_MSB       23
`define UUL_UNIT_LSB       16
`define UUL_TIME_MSB       15
`define UUL_TIME_LSB       8
`define UUL_POS_MASK       32'hFFFF0000
`define UUL_SPD_MASK       32'hFFFFFF00
`define UUL_EXP_MAX        8'h06
`define UUL_EXP_MIN        8'hFA
// Reset values
`define UUL_RST_POS        32'hFF410000
`define UUL_RST_SPD        32'h00B44700
`define UUL_RST_FACT       32'h00000001
// Limit reaction codes, two's complement
`define UUL_RC_DISCARD     8'hFE
`define UUL_RC_NOTE        8'hFF
`define UUL_RC_OFF         8'h00
`define UUL_RC_SLOW_SOD    8'h01
`define UUL_RC_QUICK_SOD   8'h02
`define UUL_RC_SLOW_QSA    8'h05
`define UUL_RC_QUICK_QSA   8'h06
// Status word layout
`define UUL_WARN_BIT       7
// Control cycle timing
`define UUL_CLK_HZ         50000000
`define UUL_CYCLE_US       1000
`define UUL_CYCLE_CLKS     (`UUL_CYCLE_US * (`UUL_CLK_HZ / 1000000))
`endif

// *** src/uul_tick.v ***
// Control-cycle enable: one pulse every CYCLE_CLKS system clocks.
// Assumes CYCLE_CLKS is at least 2 and below 65536.
`timescale 1ns/10ps
module uul_tick #(
  parameter CYCLE_CLKS = 50000
) (
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  output reg         tick_o
);
  localparam [15:0] LAST = CYCLE_CLKS[15:0] - 16'h0001;
  reg [15:0] cnt;

  // Free-running divider
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == LAST);
      cnt    <= (cnt == LAST) ? 16'h0000 : cnt + 16'h0001;
    end
  end
endmodule // uul_tick

// *** src/uul_cfg_store.v ***
// Shadow and active copies of the unit words and scale factors.
// Assumes writes arrive already checked and with reserved bits cleared.
`timescale 1ns/10ps
`include "uul_defines.vh"
module uul_cfg_store (
  input  wire         sys_clk_i,
  input  wire         arst_n_i,
  input  wire         wr_i,
  input  wire [3:0]   wr_slot_i,
  input  wire [31:0]  wr_data_i,
  input  wire [3:0]   rd_slot_i,
  input  wire         apply_i,
  input  wire         vel_mode_i,
  output wire [31:0]  rd_data_o,
  output wire [319:0] act_o
);
  reg [31:0] shadow [0:9];
  reg [31:0] active [0:9];
  integer i;

  // Reads see the shadow so software gets back what it wrote
  assign rd_data_o = (rd_slot_i <= `UUL_SLOT_LAST) ? shadow[rd_slot_i] : 32'h00000000;

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_out
      assign act_o[g*32 +: 32] = active[g];
    end
  endgenerate

  // Shadow takes writes at once; active follows only outside operation
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < 10; i = i + 1) begin
        shadow[i] <= `UUL_RST_FACT;
        active[i] <= `UUL_RST_FACT;
      end
      shadow[0] <= `UUL_RST_POS;
      active[0] <= `UUL_RST_POS;
      shadow[1] <= `UUL_RST_SPD;
      active[1] <= `UUL_RST_SPD;
    end else begin
      if (wr_i && wr_slot_i <= `UUL_SLOT_LAST) begin
        shadow[wr_slot_i] <= wr_data_i;
      end
      if (apply_i) begin
        for (i = 0; i < 10; i = i + 1) begin
          active[i] <= shadow[i];
        end
      end
      if (vel_mode_i) begin
        active[1] <= `UUL_RST_SPD;
      end
    end
  end
endmodule // uul_cfg_store

// *** src/uul_top.v ***
// User-unit configuration and limit-switch reaction, APB register slave.
// Assumes all inputs are synchronous to sys_clk_i; the power state
// machine outside follows the request outputs.
// Functional notes
// - Position word: unit 23..16, exponent 31..24.
// - Speed word: time, position unit, exponent.
// - Velocity mode forces rpm speed unit.
// - Speed factor is numerator over denominator.
// - Acceleration factor numerator over denominator.
// - Jerk factor numerator over denominator.
// - Limit trip latches position, sets warning.
// - Code -2 discards latched position.
// - Code -1 only keeps the position.
// - Code 0 cuts driver, switch on disabled.
// - Codes 1/2 ramp then switch on disabled.
// - Codes 5/6 ramp then quick stop active.
// - Block travel past latch except -1/-2.
// - Warning clear depends on reaction code.
// - Leave quick stop on quick-stop rising edge.
// - Writing -2 erases all latched positions.
// - Unit changes wait until operation left, except the velocity-mode speed unit.
// - Position unit codes from fixed table.
// - Exponent two's complement, -6 to +6.
`timescale 1ns/10ps
`include "uul_defines.vh"
module uul_top #(
  parameter CYCLE_CLKS = `UUL_CYCLE_CLKS
) (
  input  wire         sys_clk_i,
  input  wire         arst_n_i,
  input  wire         psel_i,
  input  wire         penable_i,
  input  wire         pwrite_i,
  input  wire [17:0]  paddr_i,
  input  wire [31:0]  pwdata_i,
  output reg  [31:0]  prdata_o,
  output reg          pready_o,
  output reg          pslverr_o,
  input  wire         op_en_i,
  input  wire         vel_mode_i,
  input  wire         qs_bit_i,
  input  wire         standstill_i,
  input  wire         lim_fwd_i,
  input  wire         lim_rev_i,
  input  wire [31:0]  pos_i,
  output reg          drv_off_o,
  output reg          brake_o,
  output reg          brake_quick_o,
  output reg          req_sod_o,
  output reg          req_qsa_o,
  output reg          blk_fwd_o,
  output reg          blk_rev_o,
  output reg          warn_o,
  output wire [319:0] act_cfg_o
);
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_BRK = 4'b0010;
  localparam [3:0] ST_SOD = 4'b0100;
  localparam [3:0] ST_QSA = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [7:0]  react;
  reg         to_qsa;
  reg         lim_fwd_q;
  reg         lim_rev_q;
  reg         qs_q;
  reg  [31:0] lat_fwd;
  reg  [31:0] lat_rev;
  reg         vld_fwd;
  reg         vld_rev;
  reg         warn_fwd;
  reg         next_warn;
  wire        tick;
  wire [31:0] store_rd;
  wire [15:0] idx;
  wire [3:0]  slot;
  wire        mapped;
  wire        wr_ok;
  wire        access;
  wire        commit;
  wire        evt_fwd;
  wire        evt_rev;
  wire        evt;
  wire        rc_discard;
  wire        rc_blocks;
  wire        qs_rise;
  wire        warn_clr;
  wire [31:0] status;

  // Known position unit codes
  function unit_ok;
    input [7:0] u;
    begin
      case (u)
        8'h01, 8'hC1, 8'hC2, 8'h40, 8'h10, 8'h41, 8'h42, 8'h43,
        8'hB4, 8'hB5, 8'hAC, 8'hC0, 8'h00: unit_ok = 1'b1;
        default: unit_ok = 1'b0;
      endcase
    end
  endfunction

  // Known time unit codes
  function time_ok;
    input [7:0] t;
    begin
      case (t)
        8'h03, 8'h47, 8'h48, 8'h49, 8'h4A: time_ok = 1'b1;
        default: time_ok = 1'b0;
      endcase
    end
  endfunction

  // Exponent within plus or minus six
  function exp_ok;
    input [7:0] e;
    begin
      exp_ok = ($signed(e) <= $signed(`UUL_EXP_MAX)) &&
               ($signed(e) >= $signed(`UUL_EXP_MIN));
    end
  endfunction

  // Legal reaction codes
  function rc_ok;
    input [7:0] c;
    begin
      case (c)
        `UUL_RC_DISCARD, `UUL_RC_NOTE, `UUL_RC_OFF, `UUL_RC_SLOW_SOD,
        `UUL_RC_QUICK_SOD, `UUL_RC_SLOW_QSA, `UUL_RC_QUICK_QSA: rc_ok = 1'b1;
        default: rc_ok = 1'b0;
      endcase
    end
  endfunction

  // Register index to store slot
  function [3:0] slot_of;
    input [15:0] x;
    begin
      if (x == `UUL_IDX_POS_UNIT) begin
        slot_of = `UUL_SLOT_POS;
      end else if (x == `UUL_IDX_SPD_UNIT) begin
        slot_of = `UUL_SLOT_SPD;
      end else if (x >= `UUL_IDX_FACT_BASE && x < `UUL_IDX_REACT) begin
        slot_of = x[3:0] + 4'h2;
      end else begin
        slot_of = `UUL_SLOT_NONE;
      end
    end
  endfunction

  uul_tick #(
    .CYCLE_CLKS (CYCLE_CLKS)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_o    (tick)
  );

  // Unit words and factor pairs: speed, accel, jerk, velocity scale
  uul_cfg_store u_store (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .wr_i       (commit && slot != `UUL_SLOT_NONE),
    .wr_slot_i  (slot),
    .wr_data_i  (slot == `UUL_SLOT_POS ? (pwdata_i & `UUL_POS_MASK) :
                 slot == `UUL_SLOT_SPD ? (pwdata_i & `UUL_SPD_MASK) :
                 pwdata_i),
    .rd_slot_i  (slot),
    .apply_i    (!op_en_i),
    .vel_mode_i (vel_mode_i),
    .rd_data_o  (store_rd),
    .act_o      (act_cfg_o)
  );

  // APB decode; reads have one wait state so prdata comes from a flop
  assign idx    = paddr_i[17:2];
  assign slot   = slot_of(idx);
  assign mapped = (slot != `UUL_SLOT_NONE) || idx == `UUL_IDX_REACT ||
                  idx == `UUL_IDX_STATUS || idx == `UUL_IDX_LAT_FWD ||
                  idx == `UUL_IDX_LAT_REV;
  assign access = psel_i && penable_i;
  assign commit = access && pready_o && pwrite_i && wr_ok;

  // Write checks; zero denominators are refused too
  assign wr_ok =
    (slot == `UUL_SLOT_POS) ?
      unit_ok(pwdata_i[`UUL_UNIT_MSB:`UUL_UNIT_LSB]) &&
      exp_ok(pwdata_i[`UUL_EXP_MSB:`UUL_EXP_LSB]) :
    (slot == `UUL_SLOT_SPD) ?
      unit_ok(pwdata_i[`UUL_UNIT_MSB:`UUL_UNIT_LSB]) &&
      time_ok(pwdata_i[`UUL_TIME_MSB:`UUL_TIME_LSB]) &&
      exp_ok(pwdata_i[`UUL_EXP_MSB:`UUL_EXP_LSB]) :
    (slot != `UUL_SLOT_NONE) ? (!slot[0] || pwdata_i != 32'h00000000) :
    (idx == `UUL_IDX_REACT) ? rc_ok(pwdata_i[7:0]) : 1'b0;

  assign status = {20'h00000, state, warn_o, 5'h00, vld_rev, vld_fwd};

  // Bus answer
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= access && !pready_o;
      pslverr_o <= access && !pready_o && (pwrite_i ? !wr_ok : !mapped);
      if (access && !pready_o && !pwrite_i) begin
        if (slot != `UUL_SLOT_NONE) begin
          prdata_o <= store_rd;
        end else if (idx == `UUL_IDX_REACT) begin
          prdata_o <= {{24{react[7]}}, react};
        end else if (idx == `UUL_IDX_STATUS) begin
          prdata_o <= status;
        end else if (idx == `UUL_IDX_LAT_FWD) begin
          prdata_o <= lat_fwd;
        end else if (idx == `UUL_IDX_LAT_REV) begin
          prdata_o <= lat_rev;
        end else begin
          prdata_o <= 32'h00000000;
        end
      end
    end
  end

  // Reaction code, default is note-only
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      react <= `UUL_RC_NOTE;
    end else if (commit && idx == `UUL_IDX_REACT) begin
      react <= pwdata_i[7:0];
    end
  end

  // Switch edges are looked for once per control cycle only
  assign evt_fwd    = tick && lim_fwd_i && !lim_fwd_q;
  assign evt_rev    = tick && lim_rev_i && !lim_rev_q;
  assign evt        = evt_fwd || evt_rev;
  assign rc_discard = (react == `UUL_RC_DISCARD);
  assign rc_blocks  = !rc_discard && react != `UUL_RC_NOTE;
  assign qs_rise    = qs_bit_i && !qs_q;

  // Latched limit positions; -2 erases them and keeps them erased
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim_fwd_q <= 1'b0;
      lim_rev_q <= 1'b0;
      qs_q      <= 1'b1; // Idle level of the bit, so no false edge after reset
      lat_fwd   <= 32'h00000000;
      lat_rev   <= 32'h00000000;
      vld_fwd   <= 1'b0;
      vld_rev   <= 1'b0;
    end else begin
      qs_q <= qs_bit_i;
      if (tick) begin
        lim_fwd_q <= lim_fwd_i;
        lim_rev_q <= lim_rev_i;
      end
      if (evt_fwd) begin
        lat_fwd <= pos_i;
      end
      if (evt_rev) begin
        lat_rev <= pos_i;
      end
      if (rc_discard) begin
        vld_fwd <= 1'b0;
        vld_rev <= 1'b0;
      end else begin
        vld_fwd <= vld_fwd || evt_fwd;
        vld_rev <= vld_rev || evt_rev;
      end
    end
  end

  // Warning clears on release for -2, else on return to the latch
  assign warn_clr = rc_discard ? (!lim_fwd_i && !lim_rev_i) :
                    (!lim_fwd_i && !lim_rev_i &&
                     (warn_fwd ? $signed(pos_i) <= $signed(lat_fwd)
                               : $signed(pos_i) >= $signed(lat_rev)));

  always @* begin
    next_warn = evt || (warn_o && !warn_clr);
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warn_o   <= 1'b0;
      warn_fwd <= 1'b0;
    end else begin
      warn_o <= next_warn;
      if (evt) begin
        warn_fwd <= evt_fwd;
      end
    end
  end

  // Travel past a kept latch is blocked, the way back stays open
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blk_fwd_o <= 1'b0;
      blk_rev_o <= 1'b0;
    end else begin
      blk_fwd_o <= rc_blocks && vld_fwd && $signed(pos_i) >= $signed(lat_fwd);
      blk_rev_o <= rc_blocks && vld_rev && $signed(pos_i) <= $signed(lat_rev);
    end
  end

  // Reaction sequence toward the outer power state machine
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (evt && op_en_i && rc_blocks) begin
          next_state = (react == `UUL_RC_OFF) ? ST_SOD : ST_BRK;
        end
      end
      ST_BRK: begin
        if (standstill_i) begin
          next_state = to_qsa ? ST_QSA : ST_SOD;
        end
      end
      ST_SOD: begin
        if (!op_en_i) begin
          next_state = ST_RUN;
        end
      end
      ST_QSA: begin
        if (qs_rise) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // Ramp choice is frozen at the trip so a later code write cannot flip it
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state         <= ST_RUN;
      to_qsa        <= 1'b0;
      drv_off_o     <= 1'b0;
      brake_o       <= 1'b0;
      brake_quick_o <= 1'b0;
      req_sod_o     <= 1'b0;
      req_qsa_o     <= 1'b0;
    end else begin
      state     <= next_state;
      brake_o   <= (next_state == ST_BRK);
      req_sod_o <= (next_state == ST_SOD);
      req_qsa_o <= (next_state == ST_QSA);
      if (state == ST_RUN && next_state != ST_RUN) begin
        to_qsa        <= (react == `UUL_RC_SLOW_QSA) || (react == `UUL_RC_QUICK_QSA);
        brake_quick_o <= (react == `UUL_RC_QUICK_SOD) || (react == `UUL_RC_QUICK_QSA);
        drv_off_o     <= (react == `UUL_RC_OFF);
      end else if (next_state == ST_RUN) begin
        drv_off_o     <= 1'b0;
        brake_quick_o <= 1'b0;
      end
    end
  end
endmodule // uul_top

// *** test/uul_top_assertions.sv ***
// Port checker for uul_top: bus handshake, limit reaction, unit apply.
// Assumes it is bound into every uul_top instance.
`timescale 1ns/10ps
module uul_chk #(
  parameter CYCLE_CLKS = 8
) (
  input wire logic         sys_clk_i,
  input wire logic         arst_n_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pready_o,
  input wire logic         pslverr_o,
  input wire logic         op_en_i,
  input wire logic         vel_mode_i,
  input wire logic         qs_bit_i,
  input wire logic         lim_fwd_i,
  input wire logic         lim_rev_i,
  input wire logic         drv_off_o,
  input wire logic         brake_o,
  input wire logic         req_sod_o,
  input wire logic         req_qsa_o,
  input wire logic         blk_fwd_o,
  input wire logic         warn_o,
  input wire logic [319:0] act_cfg_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Access phase still in its single wait state
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // Velocity mode while outside operation, so the forced unit is applied
  sequence s_vel_idle;
    vel_mode_i && !op_en_i;
  endsequence
  apb_wait_a: assert property (s_access |=> pready_o)
    else $error("ready missing after access");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("error without ready");
  warn_cause_a: assert property ($rose(warn_o) |-> $past(lim_fwd_i) || $past(lim_rev_i))
    else $error("warning without a tripped switch");
  drv_off_a: assert property (drv_off_o |-> req_sod_o && !brake_o && !req_qsa_o)
    else $error("driver off outside disabled state");
  brake_end_a: assert property ($fell(brake_o) |-> req_sod_o || req_qsa_o)
    else $error("ramp ended without a stop state");
  qsa_hold_a: assert property (req_qsa_o && !qs_bit_i |=> req_qsa_o)
    else $error("quick stop left without an edge");
  qsa_exit_a: assert property ($fell(req_qsa_o) |-> $past(qs_bit_i))
    else $error("quick stop left with the bit low");
  unit_hold_a: assert property ($past(op_en_i) |-> $stable(act_cfg_o[31:0]))
    else $error("position unit changed in operation");
  vel_rpm_a: assert property (s_vel_idle ##1 s_vel_idle |=> act_cfg_o[63:32] == 32'h00B44700)
    else $error("velocity mode unit not rpm");
  blk_cause_a: assert property ($rose(blk_fwd_o) |-> warn_o)
    else $error("travel blocked without a trip");
endmodule // uul_chk

bind uul_top uul_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .op_en_i,
  .vel_mode_i, .qs_bit_i, .lim_fwd_i, .lim_rev_i, .drv_off_o, .brake_o,
  .req_sod_o, .req_qsa_o, .blk_fwd_o, .warn_o, .act_cfg_o
);

// *** test/uul_axis_model.sv ***
// Axis with forward and reverse limit switches, facing uul_top.
// Assumes the bench steers travel through run_i and dir_i.
`timescale 1ns/10ps
module uul_axis_model #(
  parameter int LIM_AT = 20
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        run_i,
  input  wire logic        dir_i,
  input  wire logic        brake_i,
  output logic      [31:0] pos_o,
  output logic             lim_fwd_o,
  output logic             lim_rev_o,
  output logic             standstill_o
);
  logic [2:0] stop_cnt;
  // A ramp takes five clocks, so braking is never seen as instant
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_o <= 32'h0;
      stop_cnt <= 3'h0;
    end else begin
      if (run_i && !standstill_o)
        pos_o <= dir_i ? pos_o - 32'h1 : pos_o + 32'h1;
      stop_cnt <= !brake_i ? 3'h0 : (standstill_o ? stop_cnt : stop_cnt + 3'h1);
    end
  end
  // Switches are plain levels, high while the axis stands beyond them
  assign standstill_o = brake_i && (stop_cnt == 3'h5);
  assign lim_fwd_o = $signed(pos_o) >= LIM_AT;
  assign lim_rev_o = $signed(pos_o) <= -LIM_AT;
endmodule // uul_axis_model

// *** test/testbench.sv ***
// Self-checking bench for uul_top with the axis model on its far side.
// Assumes a 50 MHz clock and a control cycle shortened to 8 clocks.
`timescale 1ns/10ps
`include "uul_defines.vh"
module testbench;
  localparam int CYC = 8;
  logic        sys_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [17:0] paddr_i = 18'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, pos_i, q;
  logic        op_en_i = 0, vel_mode_i = 0, qs_bit_i = 1, run = 0, dir = 0, e;
  logic        pready_o, pslverr_o, standstill_i, lim_fwd_i, lim_rev_i;
  logic        drv_off_o, brake_o, brake_quick_o, req_sod_o, req_qsa_o;
  logic        blk_fwd_o, blk_rev_o, warn_o;
  logic [319:0] act_cfg_o;
  logic [7:0]  codes [7] = '{8'hFF, 8'hFE, 8'h00, 8'h01, 8'h02, 8'h05, 8'h06};
  int          n_fail = 0, checks = 0;
  wire  [4:0]  obs = {drv_off_o, req_qsa_o, req_sod_o, brake_o, warn_o};

  uul_top #(.CYCLE_CLKS(CYC)) u_dut (
    .sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .op_en_i, .vel_mode_i, .qs_bit_i,
    .standstill_i, .lim_fwd_i, .lim_rev_i, .pos_i, .drv_off_o, .brake_o,
    .brake_quick_o, .req_sod_o, .req_qsa_o, .blk_fwd_o, .blk_rev_o, .warn_o,
    .act_cfg_o
  );
  uul_axis_model u_axis (
    .sys_clk_i, .arst_n_i, .run_i(run), .dir_i(dir), .brake_i(brake_o),
    .pos_o(pos_i), .lim_fwd_o(lim_fwd_i), .lim_rev_o(lim_rev_i),
    .standstill_o(standstill_i)
  );

  // Clock
  always #10 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask
  // One bus transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    q = prdata_o;
    e = pslverr_o;
    chk("ready", 1'b1, pready_o);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input string nm, input logic [15:0] idx, input logic [31:0] d, input logic ee);
    apb(1'b1, idx, d);
    chk(nm, ee, e);
  endtask
  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] ex);
    apb(1'b0, idx, 32'h0);
    chk(nm, ex, q);
  endtask
  // Bounded wait for one reaction output to reach a level
  task automatic wait_lv(input int s, input logic v);
    for (int n = 0; n < 300 && obs[s] !== v; n++) @(posedge sys_clk_i);
    chk("wait", v, obs[s]);
  endtask

  task automatic t_reset;
    rd("pos", `UUL_IDX_POS_UNIT, 32'hFF410000);
    rd("spd", `UUL_IDX_SPD_UNIT, 32'h00B44700);
    rd("react", `UUL_IDX_REACT, 32'hFFFFFFFF);
    rd("nomap", 16'h0000, 32'h0);
    chk("nomap_err", 1'b1, e);
    wr("status_wr", `UUL_IDX_STATUS, 32'h0, 1'b1);
  endtask

  task automatic t_units;
    op_en_i <= 1'b1;
    wr("pos_wr", `UUL_IDX_POS_UNIT, 32'hFD01ABCD, 1'b0);
    rd("pos", `UUL_IDX_POS_UNIT, 32'hFD010000);
    chk("act_pos", 32'hFF410000, act_cfg_o[31:0]);
    op_en_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk("act_pos", 32'hFD010000, act_cfg_o[31:0]);
    wr("exp_hi", `UUL_IDX_POS_UNIT, 32'h07410000, 1'b1);
    wr("exp_lo", `UUL_IDX_POS_UNIT, 32'hFA410000, 1'b0);
    wr("unit_bad", `UUL_IDX_POS_UNIT, 32'hFF550000, 1'b1);
    wr("unit_rev", `UUL_IDX_POS_UNIT, 32'hFFB40000, 1'b0);
    wr("time_bad", `UUL_IDX_SPD_UNIT, 32'hFD010500, 1'b1);
    vel_mode_i <= 1'b1;
    wr("spd_wr", `UUL_IDX_SPD_UNIT, 32'hFD0103AB, 1'b0);
    rd("spd", `UUL_IDX_SPD_UNIT, 32'hFD010300);
    chk("act_spd", 32'h00B44700, act_cfg_o[63:32]);
    vel_mode_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk("act_spd", 32'hFD010300, act_cfg_o[63:32]);
    for (int i = 0; i < 8; i++) begin
      if (i % 2) wr("den_zero", `UUL_IDX_FACT_BASE + 16'(i), 32'h0, 1'b1);
      wr("fact_wr", `UUL_IDX_FACT_BASE + 16'(i), 32'h3 + i, 1'b0);
      rd("fact", `UUL_IDX_FACT_BASE + 16'(i), 32'h3 + i);
      chk("act_fact", 32'h3 + i, act_cfg_o[64 + 32 * i +: 32]);
    end
  endtask

  // Trip the forward switch under one reaction code, then recover
  task automatic t_react(input logic [7:0] c);
    logic mv;
    mv = (c != 8'hFE) && (c != 8'hFF);
    wr("react_wr", `UUL_IDX_REACT, {{24{c[7]}}, c}, 1'b0);
    op_en_i <= 1'b1;
    dir <= 1'b0;
    run <= 1'b1;
    wait_lv(0, 1'b1);
    run <= 1'b0;
    if (mv && c != 8'h00) begin
      wait_lv(1, 1'b1);
      chk("quick", c == 8'h02 || c == 8'h06, brake_quick_o);
      wait_lv(1, 1'b0);
    end
    repeat (4) @(posedge sys_clk_i);
    chk("sod", c == 8'h00 || c == 8'h01 || c == 8'h02, req_sod_o);
    chk("qsa", c == 8'h05 || c == 8'h06, req_qsa_o);
    chk("drv_off", c == 8'h00, drv_off_o);
    chk("brake_idle", 1'b0, brake_o);
    chk("blk_fwd", mv, blk_fwd_o);
    chk("blk_rev", 1'b0, blk_rev_o);
    rd("react", `UUL_IDX_REACT, {{24{c[7]}}, c});
    apb(1'b0, `UUL_IDX_STATUS, 32'h0);
    chk("latched", c != 8'hFE, q[0]);
    chk("warn_bit", 1'b1, q[`UUL_WARN_BIT]);
    apb(1'b0, `UUL_IDX_LAT_FWD, 32'h0);
    chk("lat_fwd", 1'b1, q >= 32'd20 && q <= 32'd20 + CYC);
    if (c == 8'h05 || c == 8'h06) begin
      qs_bit_i <= 1'b0;
      repeat (2 * CYC) @(posedge sys_clk_i);
      qs_bit_i <= 1'b1;
      wait_lv(3, 1'b0);
    end
    wr("react_clr", `UUL_IDX_REACT, 32'hFFFFFFFE, 1'b0);
    apb(1'b0, `UUL_IDX_STATUS, 32'h0);
    chk("latch_erased", 1'b0, q[0]);
    dir <= 1'b1;
    run <= 1'b1;
    wait_lv(0, 1'b0);
    run <= 1'b0;
    chk("released", 1'b0, lim_fwd_i);
    op_en_i <= 1'b0;
    wait_lv(2, 1'b0);
    wait_lv(4, 1'b0);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset;
    t_units;
    foreach (codes[i]) t_react(codes[i]);
    wrap_up;
  end

  // Watchdog: the whole run needs several hundred clocks
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    wrap_up;
  end
endmodule // testbench
